//--- design/soc_pkg.sv
// Package of register map, field positions, reset values and timing for the output block
package soc_pkg;

    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam logic [7:0] OFF_MAIN_OUT_CFG  = 8'h00;
    localparam logic [7:0] OFF_CUST_CFG      = 8'h04;
    localparam logic [7:0] OFF_CAP_FE_CFG    = 8'h08;
    localparam logic [7:0] OFF_TEMP_FE_CFG   = 8'h0c;
    localparam logic [7:0] OFF_UPPER_LIMIT   = 8'h10;
    localparam logic [7:0] OFF_LOWER_LIMIT   = 8'h14;
    localparam logic [7:0] OFF_ALARM_PIN_CFG = 8'h18;
    localparam logic [7:0] OFF_IRQ_STATUS    = 8'h1c;
    localparam logic [7:0] OFF_IRQ_CLEAR     = 8'h20;
    localparam logic [7:0] OFF_IRQ_ENABLE    = 8'h24;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int MAIN_ADDR_LOCK_BIT  = 0;
    localparam int MAIN_OUT_SEL_LSB    = 1;
    localparam int MAIN_UPDATE_BIT     = 7;
    localparam int CUST_SLAVE_ADDR_LSB = 0;
    localparam int ALM_HIGH_POL_BIT    = 0;
    localparam int ALM_HIGH_OD_BIT     = 1;
    localparam int ALM_LOW_POL_BIT     = 2;
    localparam int ALM_LOW_OD_BIT      = 3;
    localparam int IRQ_MEAS_DONE_BIT   = 0;
    localparam int IRQ_CONFLICT_BIT    = 1;
    localparam int IRQ_ALM_HIGH_BIT    = 2;
    localparam int IRQ_ALM_LOW_BIT     = 3;
    localparam int IRQ_BITS            = 4;

    // ************************************************************
    // Encodings and reset values
    // ************************************************************
    localparam logic [1:0]  OUT_SEL_DENSITY     = 2'h2;
    localparam logic [15:0] RST_MAIN_OUT_CFG    = 16'h0000;
    localparam logic [15:0] RST_CUST_CFG        = 16'h0028;
    localparam logic [15:0] RST_CAP_FE_CFG      = 16'h0000;
    localparam logic [15:0] RST_TEMP_FE_CFG     = 16'h8192;
    localparam logic [15:0] RST_UPPER_LIMIT     = 16'h3fff;
    localparam logic [15:0] RST_LOWER_LIMIT     = 16'h0000;
    localparam logic [15:0] RST_ALARM_PIN_CFG   = 16'h0000;
    localparam logic [1:0]  RESP_OKAY           = 2'h0;
    localparam logic [1:0]  RESP_DECERR         = 2'h3;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_NS     = 4;
    localparam int UPDATE_PERIOD_US  = 25000;
    localparam int UPDATE_PERIOD_CYC = UPDATE_PERIOD_US * 1000 / CLK_PERIOD_NS;

endpackage

//--- design/soc_output_config.sv
// Output path selection, alarm pin drivers, density clipping and AXI4-Lite registers
//
// Chosen here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
module soc_output_config #(
    parameter int DENSITY_W     = 14,
    parameter int UPDATE_PERIOD = soc_pkg::UPDATE_PERIOD_CYC
) (
    input  wire logic                 core_clk,
    input  wire logic                 rst_n,
    // AXI4-Lite slave
    input  wire logic [7:0]           s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [7:0]           s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    // Corrected results from the correction logic
    input  wire logic [DENSITY_W-1:0] cap_value,
    input  wire logic [DENSITY_W-1:0] temp_value,
    input  wire logic                 result_valid,
    // Alarm states from the trip logic
    input  wire logic                 alarm_high_active,
    input  wire logic                 alarm_low_active,
    // Serial interface side
    input  wire logic                 meas_cmd,
    input  wire logic [6:0]           addr_rx,
    input  wire logic                 addr_rx_valid,
    output logic                      addr_ack,
    output logic                      addr_ack_valid,
    // Measurement trigger to the front end
    output logic                      meas_start,
    // Density pins
    output logic                      cap_density_out,
    output logic                      temp_density_out,
    // Alarm pins, drive enable low while driving
    output logic                      alarm_high_o,
    output logic                      alarm_high_oe_n,
    output logic                      alarm_low_o,
    output logic                      alarm_low_oe_n,
    output logic                      irq
);

    initial begin
        if (DENSITY_W < 2 || DENSITY_W > 16) begin
            $error("DENSITY_W must lie in 2..16");
        end
        if (UPDATE_PERIOD < 2) begin
            $error("UPDATE_PERIOD must be at least 2");
        end
    end

    localparam int PW = $clog2(UPDATE_PERIOD + 1);
    localparam logic [PW-1:0] PERIOD_LAST = PW'(UPDATE_PERIOD - 1);

    // ************************************************************
    // Helper functions
    // ************************************************************

    // Merge byte-lane strobes into a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] st);
        logic [15:0] r;
        r = old;
        if (st[0]) begin
            r[7:0] = wd[7:0];
        end
        if (st[1]) begin
            r[15:8] = wd[15:8];
        end
        return r;
    endfunction

    // Hold a value between the lower and upper limit
    function automatic logic [DENSITY_W-1:0] clip(input logic [DENSITY_W-1:0] v,
                                                  input logic [15:0] lo,
                                                  input logic [15:0] hi);
        logic [DENSITY_W-1:0] r;
        r = v;
        if ({{(16-DENSITY_W){1'b0}}, v} > hi) begin
            r = hi[DENSITY_W-1:0];
        end
        if ({{(16-DENSITY_W){1'b0}}, v} < lo) begin
            r = lo[DENSITY_W-1:0];
        end
        return r;
    endfunction

    // First-order density step: carry out of accumulator plus value
    function automatic logic [DENSITY_W:0] dens_step(input logic [DENSITY_W-1:0] acc,
                                                     input logic [DENSITY_W-1:0] v);
        return {1'b0, acc} + {1'b0, v};
    endfunction

    // Pin level and drive enable from alarm state, polarity and driver type
    function automatic logic [1:0] pin_drive(input logic act, input logic pol,
                                             input logic od);
        logic lvl;
        lvl = act ^ pol;
        if (od) begin
            return {lvl, 1'b0};
        end
        return {1'b0, lvl};
    endfunction

    // ************************************************************
    // Registers
    // ************************************************************
    localparam int IRQ_BITS = soc_pkg::IRQ_BITS;
    logic [15:0]         main_output_config_q;
    logic [15:0]         customer_config_q;
    logic [15:0]         capacitance_frontend_config_q;
    logic [15:0]         temperature_frontend_config_q;
    logic [15:0]         density_out_upper_limit_q;
    logic [15:0]         density_out_lower_limit_q;
    logic [15:0]         alarm_pin_config_q;
    logic [IRQ_BITS-1:0] irq_status_q;
    logic [IRQ_BITS-1:0] irq_enable_q;

    logic       aw_held_q;
    logic       w_held_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic       wr_fire;
    logic [IRQ_BITS-1:0] clr_mask;

    // Configuration decodes
    logic       density_sel;
    logic       update_mode;
    logic       addr_lock;
    logic [6:0] slave_addr;
    assign density_sel = main_output_config_q[soc_pkg::MAIN_OUT_SEL_LSB +: 2]
                         == soc_pkg::OUT_SEL_DENSITY;
    assign update_mode = main_output_config_q[soc_pkg::MAIN_UPDATE_BIT];
    assign addr_lock   = main_output_config_q[soc_pkg::MAIN_ADDR_LOCK_BIT];
    assign slave_addr  = customer_config_q[soc_pkg::CUST_SLAVE_ADDR_LSB +: 7];

    // ************************************************************
    // AXI4-Lite write channel
    // ************************************************************

    // Address and data are taken in either order and held until the write
    assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            aw_held_q     <= 1'b0;
            w_held_q      <= 1'b0;
            aw_addr_q     <= 8'h00;
            w_data_q      <= 32'h0000_0000;
            w_strb_q      <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held_q && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready  <= !w_held_q && !(s_axi_wvalid && s_axi_wready);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held_q <= 1'b0;
            end
        end
    end

    // Write response, decode error for unmapped offsets
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= soc_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            if (aw_addr_q[1:0] != 2'h0 || aw_addr_q > soc_pkg::OFF_IRQ_ENABLE) begin
                s_axi_bresp <= soc_pkg::RESP_DECERR;
            end else begin
                s_axi_bresp <= soc_pkg::RESP_OKAY;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Configuration register writes; reserved bits are stored as written, except in the interrupt enable, which keeps only its low IRQ_BITS bits
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            main_output_config_q          <= soc_pkg::RST_MAIN_OUT_CFG;
            customer_config_q             <= soc_pkg::RST_CUST_CFG;
            capacitance_frontend_config_q <= soc_pkg::RST_CAP_FE_CFG;
            temperature_frontend_config_q <= soc_pkg::RST_TEMP_FE_CFG;
            density_out_upper_limit_q     <= soc_pkg::RST_UPPER_LIMIT;
            density_out_lower_limit_q     <= soc_pkg::RST_LOWER_LIMIT;
            alarm_pin_config_q            <= soc_pkg::RST_ALARM_PIN_CFG;
            irq_enable_q                  <= '0;
        end else if (wr_fire) begin
            if (aw_addr_q == soc_pkg::OFF_MAIN_OUT_CFG) begin
                main_output_config_q <= merge16(main_output_config_q, w_data_q, w_strb_q);
            end else if (aw_addr_q == soc_pkg::OFF_CUST_CFG) begin
                customer_config_q <= merge16(customer_config_q, w_data_q, w_strb_q);
            end else if (aw_addr_q == soc_pkg::OFF_CAP_FE_CFG) begin
                capacitance_frontend_config_q <=
                    merge16(capacitance_frontend_config_q, w_data_q, w_strb_q);
            end else if (aw_addr_q == soc_pkg::OFF_TEMP_FE_CFG) begin
                temperature_frontend_config_q <=
                    merge16(temperature_frontend_config_q, w_data_q, w_strb_q);
            end else if (aw_addr_q == soc_pkg::OFF_UPPER_LIMIT) begin
                density_out_upper_limit_q <=
                    merge16(density_out_upper_limit_q, w_data_q, w_strb_q);
            end else if (aw_addr_q == soc_pkg::OFF_LOWER_LIMIT) begin
                density_out_lower_limit_q <=
                    merge16(density_out_lower_limit_q, w_data_q, w_strb_q);
            end else if (aw_addr_q == soc_pkg::OFF_ALARM_PIN_CFG) begin
                alarm_pin_config_q <= merge16(alarm_pin_config_q, w_data_q, w_strb_q);
            end else if (aw_addr_q == soc_pkg::OFF_IRQ_ENABLE && w_strb_q[0]) begin
                irq_enable_q <= w_data_q[IRQ_BITS-1:0];
            end
        end
    end

    // ************************************************************
    // AXI4-Lite read channel
    // ************************************************************

    // One-cycle read answer; narrow registers sit in the low bits
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= soc_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= soc_pkg::RESP_OKAY;
                s_axi_rdata  <= 32'h0000_0000;
                if (s_axi_araddr == soc_pkg::OFF_MAIN_OUT_CFG) begin
                    s_axi_rdata[15:0] <= main_output_config_q;
                end else if (s_axi_araddr == soc_pkg::OFF_CUST_CFG) begin
                    s_axi_rdata[15:0] <= customer_config_q;
                end else if (s_axi_araddr == soc_pkg::OFF_CAP_FE_CFG) begin
                    s_axi_rdata[15:0] <= capacitance_frontend_config_q;
                end else if (s_axi_araddr == soc_pkg::OFF_TEMP_FE_CFG) begin
                    s_axi_rdata[15:0] <= temperature_frontend_config_q;
                end else if (s_axi_araddr == soc_pkg::OFF_UPPER_LIMIT) begin
                    s_axi_rdata[15:0] <= density_out_upper_limit_q;
                end else if (s_axi_araddr == soc_pkg::OFF_LOWER_LIMIT) begin
                    s_axi_rdata[15:0] <= density_out_lower_limit_q;
                end else if (s_axi_araddr == soc_pkg::OFF_ALARM_PIN_CFG) begin
                    s_axi_rdata[15:0] <= alarm_pin_config_q;
                end else if (s_axi_araddr == soc_pkg::OFF_IRQ_STATUS) begin
                    s_axi_rdata[IRQ_BITS-1:0] <= irq_status_q;
                end else if (s_axi_araddr == soc_pkg::OFF_IRQ_CLEAR) begin
                    s_axi_rdata <= 32'h0000_0000; // Write-only, reads zero
                end else if (s_axi_araddr == soc_pkg::OFF_IRQ_ENABLE) begin
                    s_axi_rdata[IRQ_BITS-1:0] <= irq_enable_q;
                end else begin
                    s_axi_rresp <= soc_pkg::RESP_DECERR;
                end
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Measurement triggering
    // ************************************************************
    logic [PW-1:0] period_q;

    // Update mode runs a free period counter; sleep mode waits for a command
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            period_q   <= '0;
            meas_start <= 1'b0;
        end else if (update_mode) begin
            meas_start <= (period_q == PERIOD_LAST);
            if (period_q == PERIOD_LAST) begin
                period_q <= '0;
            end else begin
                period_q <= period_q + PW'(1);
            end
        end else begin
            period_q   <= '0;
            meas_start <= meas_cmd;
        end
    end

    // ************************************************************
    // Serial address answer
    // ************************************************************

    // Any address is acknowledged unless the lock bit is set
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            addr_ack       <= 1'b0;
            addr_ack_valid <= 1'b0;
        end else begin
            addr_ack_valid <= addr_rx_valid;
            if (addr_rx_valid) begin
                addr_ack <= !addr_lock || (addr_rx == slave_addr);
            end
        end
    end

    // ************************************************************
    // Density outputs
    // ************************************************************
    logic [DENSITY_W-1:0] cap_hold_q;
    logic [DENSITY_W-1:0] temp_hold_q;
    logic [DENSITY_W-1:0] cap_acc_q;
    logic [DENSITY_W-1:0] temp_acc_q;
    logic [DENSITY_W:0]   cap_sum;
    logic [DENSITY_W:0]   temp_sum;

    assign cap_sum  = dens_step(cap_acc_q, cap_hold_q);
    assign temp_sum = dens_step(temp_acc_q, temp_hold_q);

    // Latch each new result already clipped to the limits
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cap_hold_q  <= '0;
            temp_hold_q <= '0;
        end else if (result_valid) begin
            cap_hold_q  <= clip(cap_value, density_out_lower_limit_q,
                                density_out_upper_limit_q);
            temp_hold_q <= clip(temp_value, density_out_lower_limit_q,
                                density_out_upper_limit_q);
        end
    end

    // Modulators run only while the density path is selected
    always_ff @(posedge core_clk) begin
        if (!rst_n || !density_sel) begin
            cap_acc_q        <= '0;
            temp_acc_q       <= '0;
            cap_density_out  <= 1'b0;
            temp_density_out <= 1'b0;
        end else begin
            cap_acc_q        <= cap_sum[DENSITY_W-1:0];
            temp_acc_q       <= temp_sum[DENSITY_W-1:0];
            cap_density_out  <= cap_sum[DENSITY_W];
            temp_density_out <= temp_sum[DENSITY_W];
        end
    end

    // ************************************************************
    // Alarm pin drivers
    // ************************************************************
    logic [1:0] high_drv;
    logic [1:0] low_drv;
    assign high_drv = pin_drive(alarm_high_active,
                                alarm_pin_config_q[soc_pkg::ALM_HIGH_POL_BIT],
                                alarm_pin_config_q[soc_pkg::ALM_HIGH_OD_BIT]);
    assign low_drv  = pin_drive(alarm_low_active,
                                alarm_pin_config_q[soc_pkg::ALM_LOW_POL_BIT],
                                alarm_pin_config_q[soc_pkg::ALM_LOW_OD_BIT]);

    // Low alarm pin is released while the density path is selected
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            alarm_high_o    <= 1'b0;
            alarm_high_oe_n <= 1'b1;
            alarm_low_o     <= 1'b0;
            alarm_low_oe_n  <= 1'b1;
        end else begin
            alarm_high_o    <= high_drv[0];
            alarm_high_oe_n <= high_drv[1];
            alarm_low_o     <= density_sel ? 1'b0 : low_drv[0];
            alarm_low_oe_n  <= density_sel ? 1'b1 : low_drv[1];
        end
    end

    // ************************************************************
    // Interrupts
    // ************************************************************
    logic       alm_high_d1_q;
    logic       alm_low_d1_q;
    logic       conflict;
    logic       conflict_d1_q;
    logic [IRQ_BITS-1:0] irq_set;

    // Density path with sleep mode is a configuration fault
    assign conflict = density_sel && !update_mode;
    assign clr_mask = (wr_fire && aw_addr_q == soc_pkg::OFF_IRQ_CLEAR && w_strb_q[0])
                      ? w_data_q[IRQ_BITS-1:0] : '0;
    always_comb begin
        irq_set = '0;
        irq_set[soc_pkg::IRQ_MEAS_DONE_BIT] = result_valid;
        irq_set[soc_pkg::IRQ_CONFLICT_BIT]  = conflict && !conflict_d1_q;
        irq_set[soc_pkg::IRQ_ALM_HIGH_BIT]  = alarm_high_active && !alm_high_d1_q;
        irq_set[soc_pkg::IRQ_ALM_LOW_BIT]   = alarm_low_active && !alm_low_d1_q;
    end

    // Sticky status, a set in the clearing cycle wins
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            irq_status_q  <= '0;
            alm_high_d1_q <= 1'b0;
            alm_low_d1_q  <= 1'b0;
            conflict_d1_q <= 1'b0;
            irq           <= 1'b0;
        end else begin
            irq_status_q  <= (irq_status_q & ~clr_mask) | irq_set;
            alm_high_d1_q <= alarm_high_active;
            alm_low_d1_q  <= alarm_low_active;
            conflict_d1_q <= conflict;
            irq           <= |(((irq_status_q & ~clr_mask) | irq_set) & irq_enable_q);
        end
    end

endmodule

//--- test/soc_output_config_monitor.sv
// Port timing checker for the output block
`timescale 1ns/1ns
module soc_output_config_monitor (
    input wire logic core_clk, rst_n, s_axi_arvalid, s_axi_arready, s_axi_rvalid,
    input wire logic addr_rx_valid, addr_ack_valid, meas_start, cap_density_out,
    input wire logic alarm_high_active, alarm_high_o, alarm_high_oe_n, alarm_low_o,
    input wire logic alarm_low_oe_n
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Read address accepted
    sequence s_ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    chk_read_answer: assert property (s_ar_taken |=> s_axi_rvalid)
        else $error("read not answered");
    chk_ack_next: assert property (addr_rx_valid |=> addr_ack_valid)
        else $error("address not answered");
    chk_ack_cause: assert property (addr_ack_valid |-> $past(addr_rx_valid))
        else $error("stray address answer");
    chk_meas_single: assert property (meas_start |=> !meas_start)
        else $error("start wider than one cycle");
    chk_high_open: assert property (alarm_high_oe_n |-> !alarm_high_o)
        else $error("released high pin shows level");
    chk_low_open: assert property (alarm_low_oe_n |-> !alarm_low_o)
        else $error("released low pin shows level");
    chk_low_freed: assert property (cap_density_out |-> alarm_low_oe_n)
        else $error("low pin driven on density path");
    chk_high_follow: assert property ($changed(alarm_high_active) |=>
        $changed({alarm_high_o, alarm_high_oe_n})) else $error("high pin missed alarm");
endmodule
bind soc_output_config soc_output_config_monitor u_mon (.*);

//--- test/soc_host_model.sv
// Host and pulled-up alarm loads on the far side
`timescale 1ns/1ns
module soc_host_model (
    input  wire logic       core_clk, addr_ack, alarm_high_o, alarm_high_oe_n,
    input  wire logic       alarm_low_o, alarm_low_oe_n,
    output logic            meas_cmd = 1'h0, addr_rx_valid = 1'h0,
    output logic      [6:0] addr_rx = 7'h00,
    output wire logic       high_pin, low_pin
);
    // Loads pull released pins high
    assign high_pin = alarm_high_oe_n ? 1'h1 : alarm_high_o;
    assign low_pin = alarm_low_oe_n ? 1'h1 : alarm_low_o;
    // One-cycle measurement command
    task send_cmd();
        meas_cmd <= 1'h1;
        @(posedge core_clk) meas_cmd <= 1'h0;
    endtask
    // Address phase, address line scrambled once dropped
    task send_addr(input logic [6:0] a, output logic ack);
        addr_rx <= a;
        addr_rx_valid <= 1'h1;
        @(posedge core_clk) addr_rx_valid <= 1'h0;
        addr_rx <= ~a;
        @(posedge core_clk) #1 ack = addr_ack;
    endtask
endmodule

//--- test/test_sensor_output_config.sv
// Self-checking bench of the output block
`timescale 1ns/1ns
module test_sensor_output_config;
    logic core_clk = 0, rst_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, result_valid = 0, alarm_high_active = 0;
    logic alarm_low_active = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, meas_cmd, addr_rx_valid, addr_ack, addr_ack_valid, meas_start, irq;
    logic cap_density_out, temp_density_out, alarm_high_o, alarm_high_oe_n, alarm_low_o;
    logic alarm_low_oe_n, high_pin, low_pin, ack;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h3;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [13:0] cap_value = 0, temp_value = 0;
    logic [6:0] addr_rx;
    int err_total = 0, comparisons = 0, n1, n2;
    soc_output_config #(.UPDATE_PERIOD(16)) DUT (.*);
    soc_host_model host (.*);
    initial forever #2 core_clk = ~core_clk;
    task chk(input string nm, input logic [31:0] e, g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s exp %h got %h", nm, e, g);
        end
    endtask
    task wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er = 2'h0);
        {s_axi_awaddr, s_axi_wdata} <= {a, 16'h0000, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        repeat (50) begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) break;
        end
        chk("bresp", er, s_axi_bresp);
        s_axi_bready <= 1'h0;
        @(posedge core_clk);
    endtask
    task rd(input logic [7:0] a, input logic [15:0] e, input logic [1:0] er = 2'h0);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        repeat (50) begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) break;
        end
        chk("rdata", {16'h0000, e}, s_axi_rdata);
        chk("rresp", er, s_axi_rresp);
        s_axi_rready <= 1'h0;
        @(posedge core_clk);
    endtask
    task t_regs();
        rd(8'h04, soc_pkg::RST_CUST_CFG);
        rd(8'h0c, soc_pkg::RST_TEMP_FE_CFG);
        rd(8'h10, soc_pkg::RST_UPPER_LIMIT);
        wr(8'h08, 16'h0c13);
        rd(8'h08, 16'h0c13);
        rd(8'h28, 16'h0000, 2'h3);
        wr(8'h28, 16'h0001, 2'h3);
    endtask
    task t_alarm();
        {alarm_high_active, alarm_low_active} <= 2'h3;
        repeat (3) @(posedge core_clk);
        chk("pp_high", 1, {high_pin, low_pin, alarm_high_oe_n} == 3'h6);
        wr(8'h18, 16'h0003);
        chk("od_on", 0, high_pin);
        alarm_high_active <= 1'h0;
        repeat (3) @(posedge core_clk);
        chk("od_off", 3, {high_pin, alarm_high_oe_n});
    endtask
    task t_meas();
        host.send_cmd();
        #1 chk("cmd", 1, meas_start);
        wr(8'h00, 16'h0080);
        n1 = 0;
        repeat (20) @(posedge core_clk);
        repeat (32) @(posedge core_clk) n1 += meas_start;
        chk("upd", 2, n1);
    endtask
    task t_density();
        wr(8'h14, 16'h0666);
        wr(8'h10, 16'h3999);
        wr(8'h00, 16'h0084);
        {cap_value, temp_value, result_valid} <= {14'h3fff, 14'h0000, 1'h1};
        @(posedge core_clk) result_valid <= 1'h0;
        {n1, n2} = 0;
        repeat (8) @(posedge core_clk);
        repeat (16384) @(posedge core_clk) {n1, n2} = {n1 + cap_density_out, n2 + temp_density_out};
        chk("cap_ones", 32'h3999, n1);
        chk("temp_ones", 32'h0666, n2);
        chk("low_free", 1, alarm_low_oe_n);
        wr(8'h00, 16'h0000);
        repeat (4) @(posedge core_clk);
        chk("path_off", 0, cap_density_out);
    endtask
    task t_irq();
        wr(8'h20, 16'h000f);
        rd(8'h1c, 16'h0000);
        result_valid <= 1'h1;
        @(posedge core_clk) result_valid <= 1'h0;
        rd(8'h1c, 16'h0001);
        chk("masked", 0, irq);
        wr(8'h24, 16'h0001);
        repeat (2) @(posedge core_clk);
        chk("irq_on", 1, irq);
        wr(8'h20, 16'h0001);
        repeat (2) @(posedge core_clk);
        chk("irq_off", 0, irq);
    endtask
    task t_addr();
        host.send_addr(7'h11, ack);
        chk("any", 1, ack);
        wr(8'h00, 16'h0001);
        host.send_addr(7'h11, ack);
        chk("other", 0, ack);
        host.send_addr(7'h28, ack);
        chk("own", 1, ack);
    endtask
    task wrap_up();
        $display("comparisons %0d errors %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge core_clk);
        rst_n <= 1'h1;
        @(posedge core_clk);
        t_regs();
        t_alarm();
        t_meas();
        t_density();
        t_irq();
        t_addr();
        wrap_up();
    end
    initial begin
        #200000;
        err_total++;
        wrap_up();
    end
endmodule
